/* dcgp_axi_master.sv */
// bus master model: one transfer at a time, window at base 0
// assumes the slave answers within 20 cycles; moves at negedge
module dcgp_axi_master (
   // clock
   input wire clk,
   // write side
   output logic [31:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   output logic s_axi_bready,
   // read side
   output logic [31:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   output logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   int stall = 0;
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic ok);
      int i;
      logic got;
      @(negedge clk);
      s_axi_awaddr = {20'h00000, a}; // 4 KB window at base 0
      s_axi_wdata = d;
      s_axi_wstrb = s;
      {s_axi_awvalid, s_axi_wvalid} = 2'h3;
      ok = 1'b0;
      got = 1'b0;
      for (i = 0; i < 20 && !ok; i++)
      begin
         @(posedge clk);
         ok = s_axi_awready && s_axi_wready;
      end
      @(negedge clk);
      {s_axi_awvalid, s_axi_wvalid} = 2'h0;
      // released bus does not keep its last value
      s_axi_awaddr = ~s_axi_awaddr;
      s_axi_wdata = ~s_axi_wdata;
      repeat (stall) @(negedge clk);
      s_axi_bready = 1'b1;
      for (i = 0; i < 20 && !got; i++)
      begin
         @(posedge clk);
         got = s_axi_bvalid;
      end
      ok = ok && got;
      @(negedge clk);
      s_axi_bready = 1'b0;
   endtask
   task rd(input logic [11:0] a, output logic [31:0] d, output logic ok);
      int i;
      logic got;
      @(negedge clk);
      s_axi_araddr = {20'h00000, a};
      s_axi_arvalid = 1'b1;
      ok = 1'b0;
      got = 1'b0;
      for (i = 0; i < 20 && !ok; i++)
      begin
         @(posedge clk);
         ok = s_axi_arready;
      end
      @(negedge clk);
      s_axi_arvalid = 1'b0;
      s_axi_araddr = ~s_axi_araddr;
      repeat (stall) @(negedge clk);
      s_axi_rready = 1'b1;
      for (i = 0; i < 20 && !got; i++)
      begin
         @(posedge clk);
         got = s_axi_rvalid;
         d = s_axi_rdata;
      end
      ok = ok && got;
      @(negedge clk);
      s_axi_rready = 1'b0;
   endtask
endmodule

/* dcgp_channel.v */
// one gpio channel: pin value and direction registers, input sync,
// change detect. assumes pins are asynchronous to clk.
`include "dcgp_consts.vh"

module dcgp_channel #(
   parameter PIN_COUNT = 32,
   parameter [31:0] VAL_RESET = `DCGP_VAL_RESET,
   parameter [31:0] DIR_RESET = `DCGP_DIR_RESET
) (
   // clock and reset
   input wire clk,
   input wire nrst,
   // pins
   input wire [PIN_COUNT-1:0] pin_in,
   output reg [PIN_COUNT-1:0] pin_out_r,
   output reg [PIN_COUNT-1:0] pin_hiz_r,
   // register access
   input wire val_we,
   input wire dir_we,
   input wire [31:0] wdata,
   input wire [31:0] wmask,
   output wire [PIN_COUNT-1:0] rd_val,
   output wire [PIN_COUNT-1:0] rd_dir,
   // change pulse toward interrupt logic
   output reg change_r
);

////////////////////////////////////////////////////////////////////////
reg [PIN_COUNT-1:0] meta_r;
reg [PIN_COUNT-1:0] sync_r;
reg [PIN_COUNT-1:0] prev_r;
wire [PIN_COUNT-1:0] wd;
wire [PIN_COUNT-1:0] wm;
wire [PIN_COUNT-1:0] val_nxt;

assign wd = wdata[PIN_COUNT-1:0];
assign wm = wmask[PIN_COUNT-1:0];
// only output bits take the write
assign val_nxt = (pin_out_r & ~(wm & ~pin_hiz_r)) | (wd & wm & ~pin_hiz_r);

// input bits read the pin, output bits the stored value
assign rd_val = (sync_r & pin_hiz_r) | (pin_out_r & ~pin_hiz_r);
assign rd_dir = pin_hiz_r;

////////////////////////////////////////////////////////////////////////
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
   begin
      meta_r <= {PIN_COUNT{1'b0}};
      sync_r <= {PIN_COUNT{1'b0}};
      prev_r <= {PIN_COUNT{1'b0}};
      change_r <= 1'b0;
      pin_out_r <= VAL_RESET[PIN_COUNT-1:0];
      pin_hiz_r <= DIR_RESET[PIN_COUNT-1:0];
   end
   else
   begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      // any edge on a pin set as input
      change_r <= |((sync_r ^ prev_r) & pin_hiz_r);
      if (val_we)
      begin
         pin_out_r <= val_nxt;
      end
      if (dir_we)
      begin
         // one = input, zero = output, per bit; drives the hiz pins
         pin_hiz_r <= (pin_hiz_r & ~wm) | (wd & wm);
      end
   end
end

endmodule

/* dcgp_consts.vh */
// register map and field constants for the dual channel gpio port
// assumes a 32-bit register bus with byte strobes and a 4 KB window
`ifndef DCGP_CONSTS_VH
`define DCGP_CONSTS_VH

// decoded address bits, window is 4 KB
`define DCGP_DEC_MSB 11
`define DCGP_DEC_W 12

// register offsets
`define DCGP_OFS_C1_VAL 12'h000
`define DCGP_OFS_C1_DIR 12'h004
`define DCGP_OFS_C2_VAL 12'h008
`define DCGP_OFS_C2_DIR 12'h00C
`define DCGP_OFS_GIE 12'h11C
`define DCGP_OFS_ISR 12'h120
`define DCGP_OFS_IER 12'h128

// register select codes
`define DCGP_SEL_NONE 3'h0
`define DCGP_SEL_C1_VAL 3'h1
`define DCGP_SEL_C1_DIR 3'h2
`define DCGP_SEL_C2_VAL 3'h3
`define DCGP_SEL_C2_DIR 3'h4
`define DCGP_SEL_GIE 3'h5
`define DCGP_SEL_ISR 3'h6
`define DCGP_SEL_IER 3'h7

// field positions
`define DCGP_GIE_BIT 31
`define DCGP_CH1_BIT 0
`define DCGP_CH2_BIT 1

// reset values and responses
`define DCGP_ZERO32 32'h0000_0000
`define DCGP_VAL_RESET 32'h0000_0000
`define DCGP_DIR_RESET 32'hFFFF_FFFF
`define DCGP_RESP_OKAY 2'h0
`define DCGP_BYTES 4

`endif

/* dcgp_irq.v */
// interrupt registers: global enable, per-channel enable and status.
// assumes events are one-cycle pulses on clk.
`include "dcgp_consts.vh"

module dcgp_irq #(
   parameter [1:0] CHAN_MASK = 2'h1
) (
   // clock and reset
   input wire clk,
   input wire nrst,
   // register writes
   input wire gie_we,
   input wire ier_we,
   input wire isr_we,
   input wire [31:0] wdata,
   input wire [31:0] wmask,
   // channel change pulses
   input wire [1:0] evt,
   // state
   output reg gie_r,
   output reg [1:0] ier_r,
   output reg [1:0] isr_r,
   output reg irq_r
);

////////////////////////////////////////////////////////////////////////
wire [1:0] wbits;
wire [1:0] tog;
wire [1:0] isr_nxt;

assign wbits = wdata[`DCGP_CH2_BIT:`DCGP_CH1_BIT] & wmask[`DCGP_CH2_BIT:`DCGP_CH1_BIT] & CHAN_MASK;
assign tog = isr_we ? wbits : 2'h0;
// a change in the same cycle as a clearing write still sets the bit
assign isr_nxt = (isr_r ^ tog) | (evt & CHAN_MASK);

////////////////////////////////////////////////////////////////////////
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
   begin
      gie_r <= 1'b0;
      ier_r <= 2'h0;
      isr_r <= 2'h0;
      irq_r <= 1'b0;
   end
   else
   begin
      if (gie_we && wmask[`DCGP_GIE_BIT])
      begin
         gie_r <= wdata[`DCGP_GIE_BIT];
      end
      if (ier_we)
      begin
         ier_r <= (ier_r & ~(wmask[`DCGP_CH2_BIT:`DCGP_CH1_BIT] & CHAN_MASK)) | wbits;
      end
      isr_r <= isr_nxt;
      // level output, one cycle behind the status
      irq_r <= gie_r & |(isr_r & ier_r);
   end
end

endmodule

/* dcgp_properties.sv */
// port assertions for the dual channel gpio port
// assumes bind into dcgp_top, one clock clk, nrst active low
module dcgp_properties #(
   parameter CH1_PIN_COUNT = 32
) (
   // clock and reset
   input wire clk,
   input wire nrst,
   // write side
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // read side
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // interrupt and pins
   input wire irq_out,
   input wire [CH1_PIN_COUNT-1:0] chan1_pin_in,
   input wire [CH1_PIN_COUNT-1:0] chan1_pin_out,
   input wire [CH1_PIN_COUNT-1:0] chan1_pin_hiz
);
   localparam W = CH1_PIN_COUNT;
   wire [31:0] lane = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
      {8{s_axi_wstrb[0]}}};
   wire [W-1:0] wen = lane[W-1:0] & ~chan1_pin_hiz;
   wire [W-1:0] out_exp = (chan1_pin_out & ~wen) | (s_axi_wdata[W-1:0] & wen);
   wire [W-1:0] hiz_exp = (chan1_pin_hiz & ~lane[W-1:0]) | (s_axi_wdata[W-1:0] & lane[W-1:0]);
   wire wr_val = s_axi_awready && s_axi_awaddr[11:0] == 12'h000;
   wire wr_dir = s_axi_awready && s_axi_awaddr[11:0] == 12'h004;
   reg [W-1:0] pin_d_r;
   reg [7:0] hist_r;
   // pin change history, irq may only rise a few edges after one, or two edges after a write
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_d_r <= {W{1'b0}};
         hist_r <= 8'h00;
      end
      else
      begin
         pin_d_r <= chan1_pin_in;
         hist_r <= {hist_r[6:0], chan1_pin_in != pin_d_r};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////
   sequence s_wr_ans;
      s_axi_awready && s_axi_wready ##1 s_axi_bvalid && s_axi_bresp == 2'h0;
   endsequence
   sequence s_rd_ans;
      s_axi_arready ##1 s_axi_rvalid && s_axi_rresp == 2'h0;
   endsequence
   property p_wr_take;
      s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid |=> s_wr_ans;
   endproperty
   a_wr_take: assert property (p_wr_take) else $error("write not answered");
   property p_rd_take;
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_rd_ans;
   endproperty
   a_rd_take: assert property (p_rd_take) else $error("read not answered");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_out_wr;
      wr_val |=> chan1_pin_out == $past(out_exp);
   endproperty
   a_out_wr: assert property (p_out_wr) else $error("pin out wrong");
   property p_out_only;
      $changed(chan1_pin_out) |-> $past(wr_val);
   endproperty
   a_out_only: assert property (p_out_only) else $error("pin out moved");
   property p_hiz_wr;
      wr_dir |=> chan1_pin_hiz == $past(hiz_exp);
   endproperty
   a_hiz_wr: assert property (p_hiz_wr) else $error("hiz wrong");
   property p_hiz_only;
      $changed(chan1_pin_hiz) |-> $past(wr_dir);
   endproperty
   a_hiz_only: assert property (p_hiz_only) else $error("hiz moved");
   property p_irq_rise;
      $rose(irq_out) |-> $past(s_axi_awready, 2) || (|hist_r);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose alone");
   property p_irq_fall;
      $fell(irq_out) |-> $past(s_axi_awready, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule

bind dcgp_top dcgp_properties #(.CH1_PIN_COUNT(CH1_PIN_COUNT)) u_props (
   .clk(clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_out(irq_out),
   .chan1_pin_in(chan1_pin_in), .chan1_pin_out(chan1_pin_out), .chan1_pin_hiz(chan1_pin_hiz));

/* dcgp_top.v */
// dual channel gpio port: 32-bit axi4-lite slave with pin registers
// and optional change interrupt. assumes one clock, pins asynchronous.
`include "dcgp_consts.vh"

// What this block does
// - each channel has a build-time pin count from 1 to 32
// - dual-channel parameter zero builds one channel, one builds two; default one channel
// - interrupt parameter zero omits interrupt logic and registers; default zero
// - four registers at offsets 0x00, 0x04, 0x08, 0x0C for both channels
// - byte strobes select which byte lanes a write updates
// - writes to unbuilt registers are completed but change nothing
// - reads of unbuilt registers return all zeros
// - channel two registers exist only in the dual build
// - data and direction registers hold only the channel's pin count
// - input pins read back their sampled level
// - a data write leaves input bits unchanged
// - a data write stores output bits and drives them to the pins
// - direction one makes a pin input, zero output, per pin
// - with interrupts built, input changes of an enabled channel raise a level interrupt
// - each channel reports input changes into its status bit
// - global enable clear blocks the interrupt output
// - one enable bit per channel masks its status
// - status register is readable and toggle-on-write
// - software may set a status bit to force an interrupt
// - reset loads per-channel parameter values into data and direction
// - direction bits drive the three-state control outputs
// - global enable is bit 31; other bits read zero
// - enable and status bit 0 is channel one, bit 1 channel two
module dcgp_top #(
   parameter CH1_PIN_COUNT = 32,
   parameter CHAN2_PIN_COUNT = 32,
   parameter SECOND_CHANNEL_PRESENT = 0,
   parameter IRQ_PRESENT = 0,
   parameter [31:0] CH1_VAL_RESET = `DCGP_VAL_RESET,
   parameter [31:0] CH1_DIR_RESET = `DCGP_DIR_RESET,
   parameter [31:0] CH2_VAL_RESET = `DCGP_VAL_RESET,
   parameter [31:0] CH2_DIR_RESET = `DCGP_DIR_RESET
) (
   // clock and reset
   input wire clk,
   input wire nrst,
   // write address channel
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // write data channel
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // write response channel
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // read address channel
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // read data channel
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // interrupt
   output wire irq_out,
   // channel one pins
   input wire [CH1_PIN_COUNT-1:0] chan1_pin_in,
   output wire [CH1_PIN_COUNT-1:0] chan1_pin_out,
   output wire [CH1_PIN_COUNT-1:0] chan1_pin_hiz,
   // channel two pins
   input wire [CHAN2_PIN_COUNT-1:0] chan2_pin_in,
   output wire [CHAN2_PIN_COUNT-1:0] chan2_pin_out,
   output wire [CHAN2_PIN_COUNT-1:0] chan2_pin_hiz
);

////////////////////////////////////////////////////////////////////////
// decode of one address into a select code; unbuilt registers map to
// none, so writes drop and reads give zero from the same place
function [2:0] reg_sel;
   input [31:0] addr;
   reg [`DCGP_DEC_MSB:0] ofs;
   begin
      // only the low 4 KB decode, the window covers at least that
      ofs = addr[`DCGP_DEC_MSB:0];
      case (ofs)
         `DCGP_OFS_C1_VAL: reg_sel = `DCGP_SEL_C1_VAL;
         `DCGP_OFS_C1_DIR: reg_sel = `DCGP_SEL_C1_DIR;
         `DCGP_OFS_C2_VAL:
            reg_sel = (SECOND_CHANNEL_PRESENT != 0) ? `DCGP_SEL_C2_VAL : `DCGP_SEL_NONE;
         `DCGP_OFS_C2_DIR:
            reg_sel = (SECOND_CHANNEL_PRESENT != 0) ? `DCGP_SEL_C2_DIR : `DCGP_SEL_NONE;
         `DCGP_OFS_GIE:
            reg_sel = (IRQ_PRESENT != 0) ? `DCGP_SEL_GIE : `DCGP_SEL_NONE;
         `DCGP_OFS_ISR:
            reg_sel = (IRQ_PRESENT != 0) ? `DCGP_SEL_ISR : `DCGP_SEL_NONE;
         `DCGP_OFS_IER:
            reg_sel = (IRQ_PRESENT != 0) ? `DCGP_SEL_IER : `DCGP_SEL_NONE;
         default: reg_sel = `DCGP_SEL_NONE;
      endcase
   end
endfunction

// byte strobes widened to a bit mask
function [31:0] strb_mask;
   input [3:0] strb;
   integer i;
   begin
      strb_mask = `DCGP_ZERO32;
      for (i = 0; i < `DCGP_BYTES; i = i + 1)
      begin
         strb_mask[i*8 +: 8] = {8{strb[i]}};
      end
   end
endfunction

////////////////////////////////////////////////////////////////////////
// write path: address and data are taken together, one at a time
wire wr_go;
wire [2:0] wr_sel;
wire [31:0] wmask;
wire wr_do;

assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
assign wr_do = s_axi_awready;
assign wr_sel = reg_sel(s_axi_awaddr);
assign wmask = strb_mask(s_axi_wstrb);

always @(posedge clk or negedge nrst)
begin
   if (!nrst)
   begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DCGP_RESP_OKAY;
   end
   else
   begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      // every write completes okay, mapped or not
      s_axi_bresp <= `DCGP_RESP_OKAY;
      if (wr_do)
      begin
         s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////
// channels
wire [CH1_PIN_COUNT-1:0] c1_rd_val;
wire [CH1_PIN_COUNT-1:0] c1_rd_dir;
wire c1_change;
wire [CHAN2_PIN_COUNT-1:0] c2_rd_val;
wire [CHAN2_PIN_COUNT-1:0] c2_rd_dir;
wire c2_change;

dcgp_channel #(
   .PIN_COUNT(CH1_PIN_COUNT),
   .VAL_RESET(CH1_VAL_RESET),
   .DIR_RESET(CH1_DIR_RESET)
) u_chan1 (
   .clk(clk),
   .nrst(nrst),
   .pin_in(chan1_pin_in),
   .pin_out_r(chan1_pin_out),
   .pin_hiz_r(chan1_pin_hiz),
   .val_we(wr_do && wr_sel == `DCGP_SEL_C1_VAL),
   .dir_we(wr_do && wr_sel == `DCGP_SEL_C1_DIR),
   .wdata(s_axi_wdata),
   .wmask(wmask),
   .rd_val(c1_rd_val),
   .rd_dir(c1_rd_dir),
   .change_r(c1_change)
);

generate
   if (SECOND_CHANNEL_PRESENT != 0)
   begin : g_chan2
      wire [CHAN2_PIN_COUNT-1:0] rv;
      wire [CHAN2_PIN_COUNT-1:0] rd;
      dcgp_channel #(
         .PIN_COUNT(CHAN2_PIN_COUNT),
         .VAL_RESET(CH2_VAL_RESET),
         .DIR_RESET(CH2_DIR_RESET)
      ) u_chan2 (
         .clk(clk),
         .nrst(nrst),
         .pin_in(chan2_pin_in),
         .pin_out_r(chan2_pin_out),
         .pin_hiz_r(chan2_pin_hiz),
         .val_we(wr_do && wr_sel == `DCGP_SEL_C2_VAL),
         .dir_we(wr_do && wr_sel == `DCGP_SEL_C2_DIR),
         .wdata(s_axi_wdata),
         .wmask(wmask),
         .rd_val(rv),
         .rd_dir(rd),
         .change_r(c2_change)
      );
      // padding happens in the read mux, a zero-width pad would not elaborate
      assign c2_rd_val = rv;
      assign c2_rd_dir = rd;
   end
   else
   begin : g_no_chan2
      // single build: pins held inactive, registers absent
      assign chan2_pin_out = {CHAN2_PIN_COUNT{1'b0}};
      assign chan2_pin_hiz = {CHAN2_PIN_COUNT{1'b1}};
      assign c2_rd_val = {CHAN2_PIN_COUNT{1'b0}};
      assign c2_rd_dir = {CHAN2_PIN_COUNT{1'b0}};
      assign c2_change = 1'b0;
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// interrupt logic, only in the interrupt build
wire global_irq_enable;
wire [1:0] ier;
wire [1:0] isr;

generate
   if (IRQ_PRESENT != 0)
   begin : g_irq
      dcgp_irq #(
         .CHAN_MASK((SECOND_CHANNEL_PRESENT != 0) ? 2'h3 : 2'h1)
      ) u_irq (
         .clk(clk),
         .nrst(nrst),
         .gie_we(wr_do && wr_sel == `DCGP_SEL_GIE),
         .ier_we(wr_do && wr_sel == `DCGP_SEL_IER),
         .isr_we(wr_do && wr_sel == `DCGP_SEL_ISR),
         .wdata(s_axi_wdata),
         .wmask(wmask),
         .evt({c2_change, c1_change}),
         .gie_r(global_irq_enable),
         .ier_r(ier),
         .isr_r(isr),
         .irq_r(irq_out)
      );
   end
   else
   begin : g_no_irq
      assign global_irq_enable = 1'b0;
      assign ier = 2'h0;
      assign isr = 2'h0;
      assign irq_out = 1'b0;
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// read path: data is sampled on the same edge that the address is taken
wire rd_go;
reg [31:0] rd_mux;

assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

always @*
begin
   rd_mux = `DCGP_ZERO32;
   case (reg_sel(s_axi_araddr))
      `DCGP_SEL_C1_VAL: rd_mux[CH1_PIN_COUNT-1:0] = c1_rd_val;
      `DCGP_SEL_C1_DIR: rd_mux[CH1_PIN_COUNT-1:0] = c1_rd_dir;
      `DCGP_SEL_C2_VAL: rd_mux[CHAN2_PIN_COUNT-1:0] = c2_rd_val;
      `DCGP_SEL_C2_DIR: rd_mux[CHAN2_PIN_COUNT-1:0] = c2_rd_dir;
      `DCGP_SEL_GIE: rd_mux[`DCGP_GIE_BIT] = global_irq_enable;
      `DCGP_SEL_ISR: rd_mux[`DCGP_CH2_BIT:`DCGP_CH1_BIT] = isr;
      `DCGP_SEL_IER: rd_mux[`DCGP_CH2_BIT:`DCGP_CH1_BIT] = ier;
      default: rd_mux = `DCGP_ZERO32;
   endcase
end

always @(posedge clk or negedge nrst)
begin
   if (!nrst)
   begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `DCGP_ZERO32;
      s_axi_rresp <= `DCGP_RESP_OKAY;
   end
   else
   begin
      s_axi_arready <= rd_go;
      s_axi_rresp <= `DCGP_RESP_OKAY;
      if (s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end
end

endmodule

/* tb.sv */
// self-checking bench: dual build with interrupts, 8 and 4 pins
// assumes dcgp_top and the master model; pins move at negedge
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;} dcgp_row_t;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] c1_in = 8'h00;
   logic [3:0] c2_in = 4'h0;
   wire [31:0] awaddr, wdata, araddr, rdata;
   wire [3:0] wstrb;
   wire [1:0] bresp, rresp;
   wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
   wire [7:0] c1_out, c1_hiz;
   wire [3:0] c2_out, c2_hiz;
   int mismatches = 0;
   int num_checks = 0;
   logic row_ok;
   dcgp_row_t rows [8] = '{'{12'h004, 32'hFFFFFF0F, 4'hF, 32'h0000000F},
      '{12'h000, 32'hFFFFFFC3, 4'hF, 32'h000000C0}, '{12'h000, 32'h0000000F, 4'h0, 32'h000000C0},
      '{12'h00C, 32'hFFFFFFF6, 4'hF, 32'h00000006}, '{12'h008, 32'hFFFFFFFF, 4'hF, 32'h00000009},
      '{12'h010, 32'hFFFFFFFF, 4'hF, 32'h00000000}, '{12'h11C, 32'h7FFFFFFF, 4'hF, 32'h00000000},
      '{12'h128, 32'hFFFFFFFF, 4'hF, 32'h00000003}};
   always #12.5 clk = ~clk;
   dcgp_top #(.CH1_PIN_COUNT(8), .CHAN2_PIN_COUNT(4), .SECOND_CHANNEL_PRESENT(1),
      .IRQ_PRESENT(1), .CH1_VAL_RESET(32'h0000005A)) dut (
      .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq_out(irq), .chan1_pin_in(c1_in), .chan1_pin_out(c1_out), .chan1_pin_hiz(c1_hiz),
      .chan2_pin_in(c2_in), .chan2_pin_out(c2_out), .chan2_pin_hiz(c2_hiz));
   dcgp_axi_master u_master (.clk(clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   ////////////////////////////////////////////////////////////
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk_rd(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task chk_pin(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] pin %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic ok;
      u_master.wr(a, d, 4'hF, ok);
      chk_rd("write handshake", 32'h1, {31'h0, ok});
      if (!ok)
         test_done;
   endtask
   task rd_chk(input logic [11:0] a, input logic [31:0] e);
      logic ok;
      logic [31:0] g;
      u_master.rd(a, g, ok);
      chk_rd("read handshake", 32'h1, {31'h0, ok});
      if (!ok)
         test_done;
      chk_rd($sformatf("reg %h", a), e, g);
   endtask
   task wait_irq(input logic e);
      int i;
      for (i = 0; i < 20 && irq !== e; i++)
         @(negedge clk);
      chk_pin("irq_out", {31'h0, e}, {31'h0, irq});
   endtask
   initial
   begin
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      chk_pin("c1 out", 32'h5A, {24'h0, c1_out});
      chk_pin("c1 hiz", 32'hFF, {24'h0, c1_hiz});
      chk_pin("c2 hiz", 32'hF, {28'h0, c2_hiz});
      rd_chk(12'h000, 32'h00000000);
      rd_chk(12'h128, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         u_master.wr(rows[i].a, rows[i].d, rows[i].s, row_ok);
         chk_rd("write handshake", 32'h1, {31'h0, row_ok});
         rd_chk(rows[i].a, rows[i].e);
      end
      chk_pin("c1 out", 32'hCA, {24'h0, c1_out});
      chk_pin("c2 out", 32'h9, {28'h0, c2_out});
      chk_pin("c2 hiz", 32'h6, {28'h0, c2_hiz});
      $display("test table done");
      // both channels change while the global enable is still clear
      c1_in = 8'h05;
      c2_in = 4'h4;
      repeat (8) @(negedge clk);
      chk_pin("irq_out", 32'h0, {31'h0, irq});
      rd_chk(12'h120, 32'h3);
      rd_chk(12'h000, 32'h000000C5);
      rd_chk(12'h008, 32'h0000000D);
      wr(12'h11C, 32'h80000000);
      wait_irq(1'b1);
      rd_chk(12'h11C, 32'h80000000);
      // channel one stays pending but masked
      wr(12'h128, 32'h2);
      wr(12'h120, 32'h2);
      wait_irq(1'b0);
      wr(12'h120, 32'h2);
      wait_irq(1'b1);
      wr(12'h120, 32'h0);
      rd_chk(12'h120, 32'h3);
      wr(12'h120, 32'h3);
      rd_chk(12'h120, 32'h0);
      wait_irq(1'b0);
      $display("test irq done");
      u_master.stall = 2;
      wr(12'h004, 32'h3);
      rd_chk(12'h004, 32'h3);
      u_master.stall = 0;
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      chk_pin("c1 out", 32'h5A, {24'h0, c1_out});
      nrst = 1'b1;
      rd_chk(12'h004, 32'hFF);
      $display("test stall and reset done");
      test_done;
   end
endmodule
